// ===== common/ifs_defs.svh
// constants of the interrupt and fifo status block
`ifndef IFS_DEFS_SVH
`define IFS_DEFS_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define IFS_A_ST_BASE    8'h00
`define IFS_A_MASK_BASE  8'h10
`define IFS_A_FIFO       8'h20
`define IFS_A_FSTAT      8'h24
`define IFS_A_WL         8'h28
`define IFS_A_CMD        8'h2C
`define IFS_A_RFW        8'h30
`define IFS_GRP_HI       3
`define IFS_GRP_LO       2
`define IFS_PAGE_HI      7
`define IFS_PAGE_LO      4
`define IFS_PAGE_ST      4'h0
`define IFS_PAGE_MASK    4'h1

// ------------------------------------------------------------
// group indices and internal event bit positions
// ------------------------------------------------------------
`define IFS_G_MAIN       0
`define IFS_G_TMR        1
`define IFS_G_ERR        2
`define IFS_G_PT         3
`define IFS_B_WL         3
`define IFS_B_RFTO       4
`define IFS_B_BRF        5
`define IFS_B_FERR       6
`define IFS_B_SLOT       6

// ------------------------------------------------------------
// command bits, status fields, reset values, counts
// ------------------------------------------------------------
`define IFS_C_DEF        0
`define IFS_C_STOP       1
`define IFS_C_CLRF       2
`define IFS_FS_OVF       16
`define IFS_FS_UNF       17
`define IFS_WL_RX_LO     16
`define IFS_MASK_RST     8'h00
`define IFS_TXWL_RST     9'h040
`define IFS_RXWL_RST     9'h100
`define IFS_RFW_RST      16'h0400
`define IFS_TSN_TOTAL    5'h18
`define IFS_TSN_LOW      5'h04

`endif

// ===== common/ifs_pkg.sv
// types shared by the interrupt and fifo status block
package ifs_pkg;

    // one byte of event pulses per status group
    typedef struct packed {
        logic [7:0] pt;
        logic [7:0] err;
        logic [7:0] tmr;
        logic [7:0] main;
    } ifs_evt_s;

    // fifo condition as seen by software
    typedef struct packed {
        logic       unf;
        logic       ovf;
        logic [9:0] cnt;
    } ifs_fstat_s;

endpackage

// ===== hw/ifs_fifo_mem.sv
// byte memory behind the data fifo, registered read
module ifs_fifo_mem #(
    parameter int DW    = 8,
    parameter int DEPTH = 512,
    parameter int AW    = 9
) (
    input  wire logic          pclk,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);

    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // no reset: contents are only ever read behind a nonzero count
    always_ff @(posedge pclk) begin
        rd_data <= mem[rd_addr];
    end

endmodule

// ===== hw/ifs_top.sv
// interrupt status, mask, irq pin and 512-byte data fifo with apb access
//
// Design decisions made here: the placing of the registers and register access over APB.
`include "ifs_defs.svh"

module ifs_top #(
    parameter int          FIFO_DEPTH  = 512,
    parameter int          AW          = 9,
    parameter logic [15:0] RFW_DEFAULT = `IFS_RFW_RST
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire ifs_pkg::ifs_evt_s evt_in,
    input  wire logic            tx_active,
    input  wire logic            rx_start,
    input  wire logic            rx_push,
    input  wire logic [7:0]      rx_data,
    input  wire logic            tx_pop,
    output logic      [7:0]      tx_data,
    input  wire logic            active_target,
    input  wire logic            field_off,
    input  wire logic            ext_field_pin,
    input  wire logic            brd_mode,
    input  wire logic            rx_frame_start,
    input  wire logic            rate_found,
    input  wire logic            tsn_reload,
    input  wire logic            tsn_use,
    output logic                 irq
);

    // ------------------------------------------------------------
    // apb slave: one wait state, answer on the second access cycle
    // ------------------------------------------------------------
    logic            acc, done, wr_done, rd_done, capture;
    logic            pready_q, pslverr_q, irq_q;
    logic [31:0]     prdata_q, rd_val;
    logic [7:0]      tx_data_q;

    assign acc     = psel & penable;
    assign capture = acc & ~pready_q;
    assign done    = acc & pready_q;
    assign wr_done = done & pwrite;
    assign rd_done = done & ~pwrite;

    function automatic logic is_page(input logic [7:0] a, input logic [3:0] pg);
        is_page = (a[`IFS_PAGE_HI:`IFS_PAGE_LO] == pg);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = is_page(a, `IFS_PAGE_ST) || is_page(a, `IFS_PAGE_MASK) ||
                 a == `IFS_A_FIFO || a == `IFS_A_FSTAT || a == `IFS_A_WL ||
                 a == `IFS_A_CMD || a == `IFS_A_RFW;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q <= capture;
            if (capture) begin
                pslverr_q <= ~mapped(paddr);
                prdata_q  <= pwrite ? 32'h0000_0000 : rd_val;
            end
        end
    end

    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign prdata  = prdata_q;
    assign irq     = irq_q;
    assign tx_data = tx_data_q;

    // ------------------------------------------------------------
    // commands
    // ------------------------------------------------------------
    logic cmd_wr, cmd_def, cmd_stop, cmd_clrf, clr_all, fifo_rst;

    assign cmd_wr   = wr_done && paddr == `IFS_A_CMD;
    assign cmd_def  = cmd_wr & pwdata[`IFS_C_DEF];
    assign cmd_stop = cmd_wr & pwdata[`IFS_C_STOP];
    assign cmd_clrf = cmd_wr & pwdata[`IFS_C_CLRF];
    assign clr_all  = cmd_def | cmd_stop | cmd_clrf;
    assign fifo_rst = rx_start | cmd_def | cmd_clrf;

    // ------------------------------------------------------------
    // fifo pointers, count and error flags
    // ------------------------------------------------------------
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0]   cnt_q, cnt_d;
    logic          ovf_q, unf_q, full, empty;
    logic          host_push, host_pop, push, pop, do_push, do_pop;
    logic [7:0]    mem_rd, wdat;
    logic [AW-1:0] txwl_q, rxwl_q;

    assign full      = (cnt_q == (AW+1)'(FIFO_DEPTH));
    assign empty     = (cnt_q == '0);
    assign host_push = wr_done && paddr == `IFS_A_FIFO;
    assign host_pop  = rd_done && paddr == `IFS_A_FIFO;
    assign push      = host_push | rx_push;
    assign pop       = host_pop | tx_pop;
    assign do_push   = push & ~full;
    assign do_pop    = pop & ~empty;
    assign wdat      = host_push ? pwdata[7:0] : rx_data;

    always_comb begin
        cnt_d = cnt_q;
        if (do_push && !do_pop) begin
            cnt_d = cnt_q + (AW+1)'(1);
        end else if (do_pop && !do_push) begin
            cnt_d = cnt_q - (AW+1)'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else if (fifo_rst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wp_q <= wp_q + AW'(1);
            end
            if (do_pop) begin
                rp_q <= rp_q + AW'(1);
            end
            cnt_q <= cnt_d;
        end
    end

    // a fresh error wins over a reset in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
        end else begin
            ovf_q <= (ovf_q & ~fifo_rst) | (push & full);
            unf_q <= (unf_q & ~fifo_rst) | (pop & empty);
        end
    end

    ifs_fifo_mem #(
        .DW    (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (AW)
    ) u_mem (
        .pclk    (pclk),
        .wr_en   (do_push),
        .wr_addr (wp_q),
        .wr_data (wdat),
        .rd_addr (rp_q),
        .rd_data (mem_rd)
    );

    // head byte settles one cycle after a pointer move
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data_q <= 8'h00;
        end else if (tx_pop) begin
            tx_data_q <= empty ? 8'h00 : mem_rd;
        end
    end

    // ------------------------------------------------------------
    // software settings: masks, water levels, wait time
    // ------------------------------------------------------------
    logic [3:0][7:0] mask_q;
    logic [15:0]     rfw_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= {4{`IFS_MASK_RST}};
            txwl_q <= `IFS_TXWL_RST;
            rxwl_q <= `IFS_RXWL_RST;
            rfw_q  <= 16'h0000;
        end else if (cmd_def) begin
            mask_q <= {4{`IFS_MASK_RST}};
            txwl_q <= `IFS_TXWL_RST;
            rxwl_q <= `IFS_RXWL_RST;
            rfw_q  <= RFW_DEFAULT;
        end else if (wr_done) begin
            if (is_page(paddr, `IFS_PAGE_MASK)) begin
                mask_q[paddr[`IFS_GRP_HI:`IFS_GRP_LO]] <= pwdata[7:0];
            end
            if (paddr == `IFS_A_WL) begin
                txwl_q <= pwdata[AW-1:0];
                rxwl_q <= pwdata[`IFS_WL_RX_LO+AW-1:`IFS_WL_RX_LO];
            end
            if (paddr == `IFS_A_RFW) begin
                rfw_q <= pwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // listen mode event sources
    // ------------------------------------------------------------
    logic        ef_s1, ef_s2, ef_s3, ef_q;
    logic [15:0] rft_cnt_q;
    logic        rft_run_q, rft_evt, brd_done_q, brf_evt, slot_evt, wl_evt, ferr_evt;
    logic [4:0]  tsn_left_q;

    // pin passes three stages; level taken once the last two agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ef_s1 <= 1'b0;
            ef_s2 <= 1'b0;
            ef_s3 <= 1'b0;
            ef_q  <= 1'b0;
        end else begin
            ef_s1 <= ext_field_pin;
            ef_s2 <= ef_s1;
            ef_s3 <= ef_s2;
            if (ef_s2 == ef_s3) begin
                ef_q <= ef_s3;
            end
        end
    end

    assign rft_evt = rft_run_q & ~ef_q & (rft_cnt_q == 16'h0000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rft_run_q <= 1'b0;
            rft_cnt_q <= 16'h0000;
        end else if (field_off && active_target) begin
            rft_run_q <= 1'b1;
            rft_cnt_q <= rfw_q;
        end else if (cmd_stop || ef_q || rft_evt) begin
            rft_run_q <= 1'b0;
        end else if (rft_run_q) begin
            rft_cnt_q <= rft_cnt_q - 16'h0001;
        end
    end

    // only the first frame of a detection session reports
    assign brf_evt = brd_mode & rx_frame_start & rate_found & ~brd_done_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brd_done_q <= 1'b0;
        end else begin
            brd_done_q <= brd_mode & (brd_done_q | brf_evt);
        end
    end

    assign slot_evt = tsn_use && tsn_left_q == (`IFS_TSN_LOW + 5'h01);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsn_left_q <= 5'h00;
        end else if (tsn_reload) begin
            tsn_left_q <= `IFS_TSN_TOTAL;
        end else if (tsn_use && tsn_left_q != 5'h00) begin
            tsn_left_q <= tsn_left_q - 5'h01;
        end
    end

    assign wl_evt = tx_active ? (cnt_q >= {1'b0, txwl_q} && cnt_d < {1'b0, txwl_q})
                              : (cnt_q <= {1'b0, rxwl_q} && cnt_d > {1'b0, rxwl_q});
    assign ferr_evt = (push & full) | (pop & empty);

    // ------------------------------------------------------------
    // status groups, read snapshot and irq pin
    // ------------------------------------------------------------
    logic [3:0][7:0] st_q, set_v, clr_v, snap_q;
    logic [31:0]     pend;
    logic            st_rd;
    logic [1:0]      grp;

    assign grp   = paddr[`IFS_GRP_HI:`IFS_GRP_LO];
    assign st_rd = rd_done & is_page(paddr, `IFS_PAGE_ST);

    always_comb begin
        set_v                           = evt_in;
        set_v[`IFS_G_MAIN][`IFS_B_WL]   = evt_in.main[`IFS_B_WL] | wl_evt;
        set_v[`IFS_G_TMR][`IFS_B_RFTO]  = evt_in.tmr[`IFS_B_RFTO] | rft_evt;
        set_v[`IFS_G_TMR][`IFS_B_BRF]   = evt_in.tmr[`IFS_B_BRF] | brf_evt;
        set_v[`IFS_G_ERR][`IFS_B_FERR]  = evt_in.err[`IFS_B_FERR] | ferr_evt;
        set_v[`IFS_G_PT][`IFS_B_SLOT]   = evt_in.pt[`IFS_B_SLOT] | slot_evt;
    end

    // a read clears only the bits it handed out, so later events survive; a command bit clears all
    generate
        for (genvar g = 0; g < 4; g++) begin : g_grp
            assign clr_v[g] = clr_all ? 8'hFF :
                              (st_rd && grp == 2'(g)) ? snap_q[g] : 8'h00;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    st_q[g] <= 8'h00;
                end else begin
                    st_q[g] <= (st_q[g] & ~clr_v[g]) | set_v[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snap_q <= '0;
        end else if (capture && is_page(paddr, `IFS_PAGE_ST)) begin
            snap_q[grp] <= st_q[grp];
        end
    end

    assign pend = st_q & ~mask_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |pend & ~clr_all;
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        if (is_page(paddr, `IFS_PAGE_ST)) begin
            rd_val[7:0] = st_q[grp];
        end else if (is_page(paddr, `IFS_PAGE_MASK)) begin
            rd_val[7:0] = mask_q[grp];
        end else begin
            case (paddr)
                `IFS_A_FIFO:  rd_val[7:0] = empty ? 8'h00 : mem_rd;
                `IFS_A_FSTAT: rd_val[`IFS_FS_UNF:0] = {unf_q, ovf_q, 6'h00, cnt_q};
                `IFS_A_WL: begin
                    rd_val[AW-1:0] = txwl_q;
                    rd_val[`IFS_WL_RX_LO+AW-1:`IFS_WL_RX_LO] = rxwl_q;
                end
                `IFS_A_RFW:   rd_val[15:0] = rfw_q;
                default:      rd_val = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_irq_or;
        @(posedge pclk) disable iff (!presetn)
        ##1 irq_q == $past(|pend & ~clr_all);
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("irq not or of pending");

    property p_latch;
        @(posedge pclk) disable iff (!presetn)
        (set_v != '0) |=> ((st_q & $past(set_v)) == $past(set_v));
    endproperty
    a_latch: assert property (p_latch) else $error("event not latched");

    property p_masked_quiet;
        @(posedge pclk) disable iff (!presetn)
        (pend == '0) |=> !irq_q;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("irq from masked bit");

    property p_unmask;
        @(posedge pclk) disable iff (!presetn)
        (wr_done && is_page(paddr, `IFS_PAGE_MASK) && !clr_all) ##1 (pend != '0) |=> irq_q;
    endproperty
    a_unmask: assert property (p_unmask) else $error("unmask did not raise irq");

    property p_rdclr;
        @(posedge pclk) disable iff (!presetn)
        (st_rd && set_v == '0) |=> (st_q[$past(grp)] & $past(snap_q[grp])) == 8'h00;
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("read did not clear status");

    property p_cmdclr;
        @(posedge pclk) disable iff (!presetn)
        (clr_all && set_v == '0) |=> st_q == '0 && !irq_q;
    endproperty
    a_cmdclr: assert property (p_cmdclr) else $error("command did not clear status");

    property p_ovf;
        @(posedge pclk) disable iff (!presetn)
        (push && full) |=> ovf_q && cnt_q <= (AW+1)'(FIFO_DEPTH);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");

    property p_unf;
        @(posedge pclk) disable iff (!presetn)
        (pop && empty) |=> unf_q;
    endproperty
    a_unf: assert property (p_unf) else $error("underflow not flagged");

    property p_frst;
        @(posedge pclk) disable iff (!presetn)
        (fifo_rst && !push && !pop) |=> cnt_q == '0 && !ovf_q && !unf_q;
    endproperty
    a_frst: assert property (p_frst) else $error("fifo not reset");

    property p_zero;
        @(posedge pclk) disable iff (!presetn)
        (capture && !pwrite && paddr == `IFS_A_FIFO && empty) |=> prdata_q == 32'h0000_0000;
    endproperty
    a_zero: assert property (p_zero) else $error("empty fifo read not zero");

    property p_rfto;
        @(posedge pclk) disable iff (!presetn)
        rft_evt && !(field_off && active_target) |=> st_q[`IFS_G_TMR][`IFS_B_RFTO] && !rft_run_q;
    endproperty
    a_rfto: assert property (p_rfto) else $error("timeout flag missing");

    property p_slot;
        @(posedge pclk) disable iff (!presetn)
        slot_evt && !tsn_reload |=> tsn_left_q == `IFS_TSN_LOW && st_q[`IFS_G_PT][`IFS_B_SLOT];
    endproperty
    a_slot: assert property (p_slot) else $error("slot pool low missed");

endmodule

// ===== bench/ifs_host.sv
// host model: apb master that issues register transfers
module ifs_host (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end

    // request held until pready is seen high at a rising edge; answer taken there
    // no cycle count assumed: only the bench watchdog ends a stuck wait
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ===== bench/ifs_top_tb_top.sv
// self-checking bench of the interrupt and fifo status block
module ifs_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [1:0] g;
        logic [7:0] e;
        logic [7:0] m;
        logic       i;
        logic [7:0] s;
    } ifs_row_s;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [7:0] paddr, rx_data, tx_data;
    logic [31:0] pwdata, prdata, v;
    logic tx_active, rx_start, rx_push, tx_pop, active_target, field_off;
    logic ext_field_pin, brd_mode, rx_frame_start, rate_found, tsn_reload, tsn_use;
    ifs_pkg::ifs_evt_s evt_in;
    int fails = 0;
    int comparisons = 0;
    ifs_row_s rows [6] = '{'{2'h0, 8'h01, 8'h00, 1'b1, 8'h01}, '{2'h1, 8'h80, 8'h00, 1'b1, 8'h80},
                           '{2'h2, 8'h02, 8'h00, 1'b1, 8'h02}, '{2'h3, 8'h01, 8'h00, 1'b1, 8'h01},
                           '{2'h0, 8'h04, 8'h04, 1'b0, 8'h04}, '{2'h2, 8'h10, 8'h10, 1'b0, 8'h10}};

    ifs_top #(.RFW_DEFAULT(16'h0400)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .evt_in(evt_in), .tx_active(tx_active),
        .rx_start(rx_start), .rx_push(rx_push), .rx_data(rx_data), .tx_pop(tx_pop),
        .tx_data(tx_data), .active_target(active_target), .field_off(field_off),
        .ext_field_pin(ext_field_pin), .brd_mode(brd_mode),
        .rx_frame_start(rx_frame_start), .rate_found(rate_found),
        .tsn_reload(tsn_reload), .tsn_use(tsn_use), .irq(irq)
    );
    ifs_host u_host (
        .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata)
    );

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, v, er);
    endtask

    task automatic rd(input logic [7:0] a);
        u_host.xfer(1'b0, a, 32'h0, v, er);
    endtask

    task automatic pulse(input logic [1:0] g, input logic [7:0] b);
        @(posedge pclk);
        evt_in <= 32'(b) << (8 * g);
        @(posedge pclk);
        evt_in <= '0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic end_sim;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog, far above the few thousand cycles needed
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        end_sim();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        evt_in = '0;
        rx_data = 8'h00;
        // no field seen until the second timer run, so the first wait timer run must expire
        {tx_active, rx_start, rx_push, tx_pop, active_target, field_off} = '0;
        {ext_field_pin, brd_mode, rx_frame_start, rate_found, tsn_reload, tsn_use} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        chk(irq, 1'b0);
        rd(8'h10);
        chk(v, 32'h0);
        rd(8'h28);
        chk(v, 32'h0100_0040);
        foreach (rows[i]) begin
            wr({4'h1, rows[i].g, 2'h0}, 32'(rows[i].m));
            pulse(rows[i].g, rows[i].e);
            chk(irq, rows[i].i);
            rd({4'h0, rows[i].g, 2'h0});
            chk(v, 32'(rows[i].s));
            rd({4'h0, rows[i].g, 2'h0});
            chk(v, 32'h0);
            chk(irq, 1'b0);
            wr({4'h1, rows[i].g, 2'h0}, 32'h0);
        end
        pulse(2'h0, 8'h01);
        pulse(2'h2, 8'h01);
        rd(8'h00);
        chk(v, 32'h1);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        rd(8'h08);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        wr(8'h14, 32'h1);
        pulse(2'h1, 8'h01);
        chk(irq, 1'b0);
        wr(8'h14, 32'h0);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        for (int c = 0; c < 3; c++) begin
            pulse(2'h3, 8'h02);
            wr(8'h2C, 32'h1 << c);
            repeat (2) @(posedge pclk);
            chk(irq, 1'b0);
            rd(8'h0C);
            chk(v, 32'h0);
        end
        rd(8'h20);
        chk(v, 32'h0);
        rd(8'h24);
        chk(v, 32'h0002_0000);
        wr(8'h2C, 32'h4);
        rd(8'h24);
        chk(v, 32'h0);
        wr(8'h20, 32'hA5);
        repeat (3) @(posedge pclk);
        tx_pop <= 1'b1;
        @(posedge pclk);
        tx_pop <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(tx_data, 8'hA5);
        rx_start <= 1'b1;
        @(posedge pclk);
        rx_start <= 1'b0;
        // one byte past capacity, crc bytes counted like any other
        repeat (513) begin
            @(posedge pclk);
            rx_push <= 1'b1;
            rx_data <= 8'h3C;
        end
        @(posedge pclk);
        rx_push <= 1'b0;
        rd(8'h24);
        chk(v, 32'h0001_0200);
        rd(8'h00);
        chk(v & 32'h8, 32'h8);
        rx_start <= 1'b1;
        @(posedge pclk);
        rx_start <= 1'b0;
        repeat (2) @(posedge pclk);
        rd(8'h24);
        chk(v, 32'h0);
        // host overfills in transmit direction, one byte past capacity
        tx_active <= 1'b1;
        repeat (513) wr(8'h20, 32'h5A);
        rd(8'h24);
        chk(v, 32'h0001_0200);
        tx_active <= 1'b0;
        rd(8'h3C);
        chk({v[30:0], er}, 32'h1);
        wr(8'h2C, 32'h1);
        tsn_reload <= 1'b1;
        @(posedge pclk);
        tsn_reload <= 1'b0;
        for (int n = 1; n <= 20; n++) begin
            @(posedge pclk);
            tsn_use <= 1'b1;
            @(posedge pclk);
            tsn_use <= 1'b0;
            repeat (2) @(posedge pclk);
            rd(8'h0C);
            chk(v & 32'h40, (n == 20) ? 32'h40 : 32'h0);
        end
        wr(8'h30, 32'h8);
        active_target <= 1'b1;
        field_off <= 1'b1;
        @(posedge pclk);
        field_off <= 1'b0;
        repeat (15) @(posedge pclk);
        rd(8'h04);
        chk(v & 32'h10, 32'h10);
        brd_mode <= 1'b1;
        rx_frame_start <= 1'b1;
        rate_found <= 1'b1;
        @(posedge pclk);
        rx_frame_start <= 1'b0;
        repeat (4) @(posedge pclk);
        rd(8'h04);
        chk(v & 32'h20, 32'h20);
        // field seen while the wait timer runs: no timeout may follow
        wr(8'h30, 32'h40);
        field_off <= 1'b1;
        @(posedge pclk);
        field_off <= 1'b0;
        ext_field_pin <= 1'b1;
        repeat (80) @(posedge pclk);
        rd(8'h04);
        chk(v & 32'h10, 32'h0);
        ext_field_pin <= 1'b0;
        // reset in mid-run: outputs and settings back to reset values
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk({tx_data, irq, pready}, 32'h0);
        presetn <= 1'b1;
        rd(8'h30);
        chk(v, 32'h0);
        end_sim();
    end
endmodule
